// ===== verilog/nso_top.sv
module nso_top
  import nso_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic [ADDR_W-1:0] I_ADDRESS,
  input wire logic I_READ,
  input wire logic I_WRITE,
  input wire logic [DATA_W-1:0] I_WRITEDATA,
  input wire logic [BE_W-1:0] I_BYTEENABLE,
  output logic [DATA_W-1:0] O_READDATA,
  output logic O_WAITREQUEST,
  output logic O_IRQ,
  input wire logic I_DDC_A_OSC_SEL_LSB,
  input wire logic I_DDC_A_OSC_SEL_MSB,
  input wire logic I_DDC_B_OSC_SEL_LSB,
  input wire logic I_DDC_B_OSC_SEL_MSB,
  input wire logic [SAMPLE_W-1:0] I_CHAN_A_SAMPLE,
  input wire logic [SAMPLE_W-1:0] I_CHAN_B_SAMPLE,
  output logic [SEL_W-1:0] O_DDC_A_OSC_SEL,
  output logic [SEL_W-1:0] O_DDC_B_OSC_SEL,
  output logic [PHASE_W-1:0] O_DDC_A_PHASE,
  output logic [PHASE_W-1:0] O_DDC_B_PHASE,
  output logic O_CHAN_A_OVER_FIRST,
  output logic O_CHAN_A_OVER_SECOND,
  output logic O_CHAN_B_OVER_FIRST,
  output logic O_CHAN_B_OVER_SECOND
);
  localparam int NUM_FREQ = NUM_DDC * NUM_OSC;

  typedef struct packed {
    nso_bus_state_type bus_state;
    logic waitrequest;
    logic [DATA_W-1:0] readdata;
    logic osc_select_source_mode;
    logic [NUM_DDC-1:0][SEL_W-1:0] soft_sel;
    logic [NUM_DDC-1:0][SEL_W-1:0] act_sel;
    logic [SAMPLE_W-1:0] range_limit_first;
    logic [SAMPLE_W-1:0] range_limit_second;
    logic [LEN_W-1:0] over_min_pulse_len;
    logic [NUM_FREQ-1:0][PHASE_W-1:0] freq;
    logic [NUM_FREQ-1:0][PHASE_W-1:0] phase;
    logic [NUM_DDC-1:0][PHASE_W-1:0] out_phase;
    logic [NUM_FLAG-1:0] evt_stat;
    logic [NUM_FLAG-1:0] evt_en;
    logic irq;
  } nso_top_state_type;

  nso_top_state_type r;
  nso_top_state_type next_r;

  logic [NUM_DDC*SEL_W-1:0] pin_sel_raw;
  logic [NUM_DDC*SEL_W-1:0] pin_sel;
  logic [NUM_FLAG-1:0] flag_over;
  logic [NUM_FLAG-1:0] flag_rise;
  logic [NUM_DDC-1:0][SAMPLE_W-1:0] chan_mag;

  // Byte-lane merge of a write into a stored word
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] wdata,
    input logic [BE_W-1:0] be
  );
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int b = 0; b < BE_W; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Ones' complement magnitude of a two's complement sample (negatives inverted, one below true magnitude)
  function automatic logic [SAMPLE_W-1:0] magnitude(
    input logic [SAMPLE_W-1:0] s
  );
    logic [SAMPLE_W-1:0] res;
    res = s[SAMPLE_W-1] ? ~s : s;
    return res;
  endfunction

  // Pin order within a DDC: LSB pin is bit 0, MSB pin is bit 1
  assign pin_sel_raw = {I_DDC_B_OSC_SEL_MSB, I_DDC_B_OSC_SEL_LSB,
    I_DDC_A_OSC_SEL_MSB, I_DDC_A_OSC_SEL_LSB};

  nso_sync #(
    .W(NUM_DDC * SEL_W)
  ) u_sel_sync (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_async(pin_sel_raw),
    .o_sync(pin_sel)
  );

  assign chan_mag[0] = magnitude(I_CHAN_A_SAMPLE);
  assign chan_mag[1] = magnitude(I_CHAN_B_SAMPLE);

  // Flag g: channel g/2, threshold g%2
  generate
    for (genvar g = 0; g < NUM_FLAG; g++) begin : g_flag
      nso_ovr_if #(
        .MAG_W(SAMPLE_W),
        .LW(LEN_W)
      ) ovr ();

      assign ovr.mag = chan_mag[g / 2];
      if (g % 2 == 0) begin : g_first
        assign ovr.limit = r.range_limit_first;
      end else begin : g_second
        assign ovr.limit = r.range_limit_second;
      end
      assign ovr.min_len = r.over_min_pulse_len;
      assign flag_over[g] = ovr.over;
      assign flag_rise[g] = ovr.rise;

      nso_over_det u_det (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .bus(ovr.det)
      );
    end
  endgenerate

  // Register read mux
  function automatic logic [DATA_W-1:0] read_reg(
    input nso_top_state_type s,
    input logic [ADDR_W-1:0] addr
  );
    logic [DATA_W-1:0] res;
    res = '0;
    if (addr == ADDR_CTRL) begin
      res[CTRL_MODE_BIT] = s.osc_select_source_mode;
      res[CTRL_SEL_A_LSB +: SEL_W] = s.soft_sel[0];
      res[CTRL_SEL_B_LSB +: SEL_W] = s.soft_sel[1];
    end else if (addr == ADDR_SEL_STAT) begin
      res[0 +: SEL_W] = s.act_sel[0];
      res[SEL_STAT_B_LSB +: SEL_W] = s.act_sel[1];
    end else if (addr == ADDR_LIMIT_FIRST) begin
      res[SAMPLE_W-1:0] = s.range_limit_first;
    end else if (addr == ADDR_LIMIT_SECOND) begin
      res[SAMPLE_W-1:0] = s.range_limit_second;
    end else if (addr == ADDR_MIN_LEN) begin
      res[LEN_W-1:0] = s.over_min_pulse_len;
    end else if (addr == ADDR_EVT_STAT) begin
      res[NUM_FLAG-1:0] = s.evt_stat;
    end else if (addr == ADDR_EVT_ENABLE) begin
      res[NUM_FLAG-1:0] = s.evt_en;
    end else if (addr[ADDR_W-1:FREQ_BASE_LSB] ==
      ADDR_FREQ_BASE[ADDR_W-1:FREQ_BASE_LSB]) begin
      res = s.freq[addr[FREQ_IDX_MSB:FREQ_IDX_LSB]];
    end
    return res;
  endfunction

  always_comb begin
    logic [DATA_W-1:0] cur;
    logic [DATA_W-1:0] wval;
    logic [NUM_FLAG-1:0] clr;
    logic do_write;
    cur = '0;
    wval = '0;
    clr = '0;
    do_write = 1'b0;
    next_r = r;

    // Bus handshake: one wait cycle, then a one-cycle answer
    case (r.bus_state)
      NSO_BUS_IDLE: begin
        next_r.waitrequest = 1'b1;
        if (I_READ || I_WRITE) begin
          next_r.bus_state = NSO_BUS_ACK;
          next_r.waitrequest = 1'b0;
          next_r.readdata = I_READ ? read_reg(r, I_ADDRESS) : '0;
        end
      end
      NSO_BUS_ACK: begin
        next_r.bus_state = NSO_BUS_IDLE;
        next_r.waitrequest = 1'b1;
        do_write = I_WRITE;
      end
      default: begin
        next_r.bus_state = NSO_BUS_IDLE;
        next_r.waitrequest = 1'b1;
      end
    endcase

    // Writes take effect on the edge that ends the request
    if (do_write) begin
      if (I_ADDRESS == ADDR_CTRL) begin
        cur = read_reg(r, ADDR_CTRL);
        wval = merge_bytes(cur, I_WRITEDATA, I_BYTEENABLE);
        next_r.osc_select_source_mode = wval[CTRL_MODE_BIT];
        next_r.soft_sel[0] = wval[CTRL_SEL_A_LSB +: SEL_W];
        next_r.soft_sel[1] = wval[CTRL_SEL_B_LSB +: SEL_W];
      end else if (I_ADDRESS == ADDR_LIMIT_FIRST) begin
        cur = read_reg(r, ADDR_LIMIT_FIRST);
        wval = merge_bytes(cur, I_WRITEDATA, I_BYTEENABLE);
        next_r.range_limit_first = wval[SAMPLE_W-1:0];
      end else if (I_ADDRESS == ADDR_LIMIT_SECOND) begin
        cur = read_reg(r, ADDR_LIMIT_SECOND);
        wval = merge_bytes(cur, I_WRITEDATA, I_BYTEENABLE);
        next_r.range_limit_second = wval[SAMPLE_W-1:0];
      end else if (I_ADDRESS == ADDR_MIN_LEN) begin
        cur = read_reg(r, ADDR_MIN_LEN);
        wval = merge_bytes(cur, I_WRITEDATA, I_BYTEENABLE);
        next_r.over_min_pulse_len = wval[LEN_W-1:0];
      end else if (I_ADDRESS == ADDR_EVT_CLEAR) begin
        wval = merge_bytes('0, I_WRITEDATA, I_BYTEENABLE);
        clr = wval[NUM_FLAG-1:0];
      end else if (I_ADDRESS == ADDR_EVT_ENABLE) begin
        cur = read_reg(r, ADDR_EVT_ENABLE);
        wval = merge_bytes(cur, I_WRITEDATA, I_BYTEENABLE);
        next_r.evt_en = wval[NUM_FLAG-1:0];
      end else if (I_ADDRESS[ADDR_W-1:FREQ_BASE_LSB] ==
        ADDR_FREQ_BASE[ADDR_W-1:FREQ_BASE_LSB]) begin
        cur = r.freq[I_ADDRESS[FREQ_IDX_MSB:FREQ_IDX_LSB]];
        wval = merge_bytes(cur, I_WRITEDATA, I_BYTEENABLE);
        next_r.freq[I_ADDRESS[FREQ_IDX_MSB:FREQ_IDX_LSB]] = wval;
      end
    end

    // Sticky events; a new rise beats a same-cycle clear
    next_r.evt_stat = (r.evt_stat & ~clr) | flag_rise;
    next_r.irq = |(next_r.evt_stat & next_r.evt_en);

    // Every oscillator advances, selected or not
    for (int k = 0; k < NUM_FREQ; k++) begin
      next_r.phase[k] = r.phase[k] + r.freq[k];
    end

    // Selection source: synced pins or software field
    for (int d = 0; d < NUM_DDC; d++) begin
      if (r.osc_select_source_mode) begin
        next_r.act_sel[d] = pin_sel[d*SEL_W +: SEL_W];
      end else begin
        next_r.act_sel[d] = r.soft_sel[d];
      end
      next_r.out_phase[d] = r.phase[d*NUM_OSC + r.act_sel[d]];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      r.bus_state <= NSO_BUS_IDLE;
      r.waitrequest <= 1'b1;
      r.readdata <= '0;
      r.osc_select_source_mode <= CTRL_MODE_RESET;
      r.soft_sel <= {NUM_DDC{SEL_RESET}};
      r.act_sel <= {NUM_DDC{SEL_RESET}};
      r.range_limit_first <= LIMIT_FIRST_RESET;
      r.range_limit_second <= LIMIT_SECOND_RESET;
      r.over_min_pulse_len <= MIN_LEN_RESET;
      r.freq <= {NUM_FREQ{FREQ_RESET}};
      r.phase <= '0;
      r.out_phase <= '0;
      r.evt_stat <= '0;
      r.evt_en <= '0;
      r.irq <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign O_READDATA = r.readdata;
  assign O_WAITREQUEST = r.waitrequest;
  assign O_IRQ = r.irq;
  assign O_DDC_A_OSC_SEL = r.act_sel[0];
  assign O_DDC_B_OSC_SEL = r.act_sel[1];
  assign O_DDC_A_PHASE = r.out_phase[0];
  assign O_DDC_B_PHASE = r.out_phase[1];
  assign O_CHAN_A_OVER_FIRST = flag_over[0];
  assign O_CHAN_A_OVER_SECOND = flag_over[1];
  assign O_CHAN_B_OVER_FIRST = flag_over[2];
  assign O_CHAN_B_OVER_SECOND = flag_over[3];
endmodule

// ===== verilog/nso_pkg.sv
package nso_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int BE_W = 4;
  localparam int NUM_DDC = 2;
  localparam int NUM_OSC = 4;
  localparam int SEL_W = 2;
  localparam int NUM_FLAG = 4;
  localparam int SAMPLE_W = 12;
  localparam int LEN_W = 8;
  localparam int PHASE_W = 32;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SEL_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_LIMIT_FIRST = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_LIMIT_SECOND = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_MIN_LEN = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_EVT_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_EVT_CLEAR = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_EVT_ENABLE = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_FREQ_BASE = 8'h20;
  localparam int FREQ_IDX_LSB = 2;
  localparam int FREQ_IDX_MSB = 4;
  localparam int FREQ_BASE_LSB = 5;

  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_SEL_A_LSB = 4;
  localparam int CTRL_SEL_B_LSB = 6;
  localparam int SEL_STAT_B_LSB = 2;

  localparam logic CTRL_MODE_RESET = 1'h0;
  localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;
  localparam logic [SAMPLE_W-1:0] LIMIT_FIRST_RESET = 12'h700;
  localparam logic [SAMPLE_W-1:0] LIMIT_SECOND_RESET = 12'h7F0;
  localparam logic [LEN_W-1:0] MIN_LEN_RESET = 8'h00;
  localparam logic [PHASE_W-1:0] FREQ_RESET = 32'h00000000;

  typedef enum logic [1:0] {
    NSO_BUS_IDLE = 2'b01,
    NSO_BUS_ACK = 2'b10
  } nso_bus_state_type;
endpackage

// ===== verilog/nso_ovr_if.sv
interface nso_ovr_if
  import nso_pkg::*;
#(
  parameter int MAG_W = SAMPLE_W,
  parameter int LW = LEN_W
);
  logic [MAG_W-1:0] mag;
  logic [MAG_W-1:0] limit;
  logic [LW-1:0] min_len;
  logic over;
  logic rise;
  modport det (input mag, input limit, input min_len,
    output over, output rise);
  modport ctl (output mag, output limit, output min_len,
    input over, input rise);
endinterface

// ===== verilog/nso_sync.sv
module nso_sync
  import nso_pkg::*;
#(
  parameter int W = NUM_DDC * SEL_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } nso_sync_state_type;

  nso_sync_state_type r;
  nso_sync_state_type next_r;

  // Two flops; first stage feeds only the second
  always_comb begin
    next_r = r;
    next_r.stage1 = i_async;
    next_r.stage2 = r.stage1;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_sync = r.stage2;
endmodule

// ===== verilog/nso_over_det.sv
module nso_over_det
  import nso_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  nso_ovr_if.det bus
);
  typedef struct packed {
    logic over;
    logic rise;
    logic [LEN_W-1:0] cnt;
  } nso_det_state_type;

  nso_det_state_type r;
  nso_det_state_type next_r;

  always_comb begin
    next_r = r;
    if (bus.mag > bus.limit) begin
      next_r.over = 1'b1;
      next_r.cnt = bus.min_len;
    end else if (r.cnt != '0) begin
      next_r.cnt = r.cnt - 1'b1;
    end else begin
      next_r.over = 1'b0;
    end
    next_r.rise = next_r.over && !r.over;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign bus.over = r.over;
  assign bus.rise = r.rise;
endmodule

// ===== tb/nso_top_asserts.sv
module nso_top_asserts
  import nso_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic [ADDR_W-1:0] I_ADDRESS,
  input wire logic I_WRITE,
  input wire logic [DATA_W-1:0] I_WRITEDATA,
  input wire logic O_WAITREQUEST,
  input wire logic I_DDC_A_OSC_SEL_LSB,
  input wire logic I_DDC_A_OSC_SEL_MSB,
  input wire logic I_DDC_B_OSC_SEL_LSB,
  input wire logic I_DDC_B_OSC_SEL_MSB,
  input wire logic [SAMPLE_W-1:0] I_CHAN_A_SAMPLE,
  input wire logic [SAMPLE_W-1:0] I_CHAN_B_SAMPLE,
  input wire logic [SEL_W-1:0] O_DDC_A_OSC_SEL,
  input wire logic [SEL_W-1:0] O_DDC_B_OSC_SEL,
  input wire logic O_CHAN_A_OVER_FIRST,
  input wire logic O_CHAN_A_OVER_SECOND,
  input wire logic O_CHAN_B_OVER_FIRST,
  input wire logic O_CHAN_B_OVER_SECOND
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  logic [11:0] lim1, lim2;
  logic [7:0] mlen;
  logic [8:0] ml;
  logic [8:0] q [4];
  logic [2:0] wage;
  logic [3:0] ex;
  logic acc;
  function automatic logic [11:0] mag(input logic [11:0] s);
    return s[11] ? ~s : s;
  endfunction
  assign acc = I_WRITE && !O_WAITREQUEST;
  assign ml = {1'b0, mlen};
  always_comb begin
    ex[0] = mag(I_CHAN_A_SAMPLE) > lim1;
    ex[1] = mag(I_CHAN_A_SAMPLE) > lim2;
    ex[2] = mag(I_CHAN_B_SAMPLE) > lim1;
    ex[3] = mag(I_CHAN_B_SAMPLE) > lim2;
  end
  // Shadow limits and quiet-cycle counters
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      lim1 <= LIMIT_FIRST_RESET;
      lim2 <= LIMIT_SECOND_RESET;
      mlen <= MIN_LEN_RESET;
      wage <= 3'h7;
      for (int i = 0; i < 4; i++) q[i] <= 9'h1FF;
    end else begin
      if (acc && I_ADDRESS == ADDR_LIMIT_FIRST) lim1 <= I_WRITEDATA[11:0];
      if (acc && I_ADDRESS == ADDR_LIMIT_SECOND) lim2 <= I_WRITEDATA[11:0];
      if (acc && I_ADDRESS == ADDR_MIN_LEN) mlen <= I_WRITEDATA[7:0];
      wage <= acc ? 3'h0 : (wage == 3'h7 ? wage : wage + 3'h1);
      for (int i = 0; i < 4; i++)
        q[i] <= ex[i] ? 9'h000 : (q[i] == 9'h1FF ? q[i] : q[i] + 9'h001);
    end
  end
  sequence s_ack;
    !O_WAITREQUEST;
  endsequence
  sequence s_sel_a_moved;
    $changed(O_DDC_A_OSC_SEL);
  endsequence
  a_ack_one_cycle:
    assert property (s_ack |=> O_WAITREQUEST) else $error("ack too long");
  a_sel_a_pins:
    assert property (s_sel_a_moved |-> wage < 3'h5 || O_DDC_A_OSC_SEL ==
      $past({I_DDC_A_OSC_SEL_MSB, I_DDC_A_OSC_SEL_LSB}, 3))
    else $error("sel A not from pins");
  a_sel_b_pins:
    assert property ($changed(O_DDC_B_OSC_SEL) |-> wage < 3'h5 ||
      O_DDC_B_OSC_SEL == $past({I_DDC_B_OSC_SEL_MSB, I_DDC_B_OSC_SEL_LSB}, 3))
    else $error("sel B not from pins");
  a_a_first_hold:
    assert property (q[0] <= ml |-> O_CHAN_A_OVER_FIRST)
    else $error("A first flag low");
  a_a_second_hold:
    assert property (q[1] <= ml |-> O_CHAN_A_OVER_SECOND)
    else $error("A second flag low");
  a_b_first_hold:
    assert property (q[2] <= ml |-> O_CHAN_B_OVER_FIRST)
    else $error("B first flag low");
  a_b_second_hold:
    assert property (q[3] <= ml |-> O_CHAN_B_OVER_SECOND)
    else $error("B second flag low");
  a_a_first_drop:
    assert property (q[0] > ml |-> !O_CHAN_A_OVER_FIRST)
    else $error("A first flag stuck");
  a_b_second_drop:
    assert property (q[3] > ml |-> !O_CHAN_B_OVER_SECOND)
    else $error("B second flag stuck");
endmodule

// ===== tb/nso_ctl_model.sv
module nso_ctl_model
  import nso_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_clr,
  input wire logic [SEL_W-1:0] i_code_a,
  input wire logic [SEL_W-1:0] i_code_b,
  input wire logic [NUM_FLAG-1:0] i_flags,
  output logic [3:0] o_pins,
  output logic [NUM_FLAG-1:0][7:0] o_hi_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_pins = 4'h0;
    o_hi_cnt = '0;
  end
  // Pins as LSB then MSB per converter; flag-high cycle counters
  always @(posedge i_clk) begin
    o_pins <= {i_code_b, i_code_a};
    for (int i = 0; i < NUM_FLAG; i++)
      o_hi_cnt[i] <= i_clr ? 8'h00 : o_hi_cnt[i] + {7'h00, i_flags[i]};
  end
endmodule

// ===== tb/nso_top_tb_top.sv
module nso_top_tb_top
  import nso_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, rd, wr, clr, irq, waitreq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, junk, p1, ph_a, ph_b;
  logic [3:0] be, flags, pins;
  logic [11:0] smp_a, smp_b;
  logic [1:0] code_a, code_b, sel_a, sel_b;
  logic [3:0][7:0] cnt;
  int n_fail, compares, cyc, c1;
  nso_top dut (.I_REF_CLK(clk), .I_RST(rst), .I_ADDRESS(addr), .I_READ(rd),
    .I_WRITE(wr), .I_WRITEDATA(wdata), .I_BYTEENABLE(be),
    .O_READDATA(rdata), .O_WAITREQUEST(waitreq), .O_IRQ(irq),
    .I_DDC_A_OSC_SEL_LSB(pins[0]), .I_DDC_A_OSC_SEL_MSB(pins[1]),
    .I_DDC_B_OSC_SEL_LSB(pins[2]), .I_DDC_B_OSC_SEL_MSB(pins[3]),
    .I_CHAN_A_SAMPLE(smp_a), .I_CHAN_B_SAMPLE(smp_b),
    .O_DDC_A_OSC_SEL(sel_a), .O_DDC_B_OSC_SEL(sel_b),
    .O_DDC_A_PHASE(ph_a), .O_DDC_B_PHASE(ph_b),
    .O_CHAN_A_OVER_FIRST(flags[0]), .O_CHAN_A_OVER_SECOND(flags[1]),
    .O_CHAN_B_OVER_FIRST(flags[2]), .O_CHAN_B_OVER_SECOND(flags[3]));
  nso_ctl_model ctl (.i_clk(clk), .i_clr(clr), .i_code_a(code_a),
    .i_code_b(code_b), .i_flags(flags), .o_pins(pins), .o_hi_cnt(cnt));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic finish_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] v);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    v = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, junk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(v, e);
  endtask
  task automatic step(input logic [1:0] a, input logic [1:0] b);
    @(posedge clk);
    code_a <= a;
    code_b <= b;
    repeat (6) @(posedge clk);
  endtask
  task automatic pulse(input logic b, input logic [11:0] v);
    @(posedge clk);
    if (b) smp_b <= v;
    else smp_a <= v;
    @(posedge clk);
    smp_a <= 12'h000;
    smp_b <= 12'h000;
    repeat (8) @(posedge clk);
  endtask
  task automatic zap;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic t_regs;
    rdc(ADDR_LIMIT_FIRST, 32'h700);
    rdc(ADDR_LIMIT_SECOND, 32'h7F0);
    rdc(ADDR_MIN_LEN, 32'h0);
    rdc(8'h40, 32'h0);
    rdc(ADDR_EVT_CLEAR, 32'h0);
  endtask
  task automatic t_sel;
    step(2'h3, 2'h1);
    chk({28'h0, sel_b, sel_a}, 32'h0);
    wrr(ADDR_CTRL, 32'h1);
    for (int k = 0; k < NUM_OSC; k++) begin
      step(2'(k), 2'(3 - k));
      chk({28'h0, sel_b, sel_a}, 32'(((3 - k) << 2) | k));
      rdc(ADDR_SEL_STAT, 32'(((3 - k) << 2) | k));
    end
    wrr(ADDR_CTRL, 32'h0);
    step(2'h1, 2'h2);
    chk({28'h0, sel_b, sel_a}, 32'h0);
  endtask
  task automatic t_phase;
    for (int k = 0; k < NUM_OSC; k++)
      wrr(ADDR_FREQ_BASE + 8'(4 * k), 32'(k + 1));
    wrr(ADDR_CTRL, 32'h1);
    step(2'h2, 2'h0);
    p1 = ph_a;
    c1 = cyc;
    step(2'h1, 2'h0);
    chk({30'h0, sel_a}, 32'h1);
    step(2'h2, 2'h0);
    chk(ph_a - p1, 32'(3 * (cyc - c1)));
    chk(ph_b, 32'h0);
  endtask
  task automatic t_over;
    wrr(ADDR_LIMIT_FIRST, 32'h100);
    wrr(ADDR_LIMIT_SECOND, 32'h200);
    wrr(ADDR_MIN_LEN, 32'h3);
    wrr(ADDR_EVT_CLEAR, 32'hF);
    wrr(ADDR_EVT_ENABLE, 32'hF);
    zap;
    pulse(1'b0, 12'h100);
    pulse(1'b0, 12'hEAF);
    chk(cnt, 32'h00000004);
    rdc(ADDR_EVT_STAT, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wrr(ADDR_EVT_CLEAR, 32'h1);
    rdc(ADDR_EVT_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wrr(ADDR_EVT_ENABLE, 32'h0);
    zap;
    pulse(1'b1, 12'h250);
    chk(cnt, 32'h04040000);
    rdc(ADDR_EVT_STAT, 32'hC);
    chk({31'h0, irq}, 32'h0);
    wrr(ADDR_EVT_ENABLE, 32'h8);
    rdc(ADDR_EVT_ENABLE, 32'h8);
    chk({31'h0, irq}, 32'h1);
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    finish_test;
  end
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    clr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    be = 4'hF;
    smp_a = 12'h000;
    smp_b = 12'h000;
    code_a = 2'h0;
    code_b = 2'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_sel;
    t_phase;
    t_over;
    finish_test;
  end
endmodule
bind nso_top nso_top_asserts u_chk (.I_REF_CLK, .I_RST, .I_ADDRESS,
  .I_WRITE, .I_WRITEDATA, .O_WAITREQUEST, .I_DDC_A_OSC_SEL_LSB,
  .I_DDC_A_OSC_SEL_MSB, .I_DDC_B_OSC_SEL_LSB, .I_DDC_B_OSC_SEL_MSB,
  .I_CHAN_A_SAMPLE, .I_CHAN_B_SAMPLE, .O_DDC_A_OSC_SEL, .O_DDC_B_OSC_SEL,
  .O_CHAN_A_OVER_FIRST, .O_CHAN_A_OVER_SECOND, .O_CHAN_B_OVER_FIRST,
  .O_CHAN_B_OVER_SECOND);
